// ===== hw/param_store.v
// Small register memory holding the seven tuning parameters
`timescale 1ns/1ps
`include "pid_front_consts.vh"
module param_store
(
   input  wire        clock,
   input  wire        reset_n,
   input  wire        wr_en,
   input  wire [2:0]  wr_idx,
   input  wire [15:0] wr_data,
   input  wire [2:0]  rd_idx,
   output reg  [15:0] rd_data,
   output wire [111:0] all_q
);
   reg [15:0] mem_q [0:6];
   genvar g;

   // Each word resets to its documented default
   generate
      for (g = 0; g < 7; g = g + 1)
      begin : word
         always @(posedge clock or negedge reset_n)
         begin
            if (!reset_n)
               mem_q[g] <= (g == 0) ? {12'h000, `RST_SP_SRC} :
                           (g == 1) ? `RST_KEY_VAL :
                           (g == 2) ? `RST_RAMP_TIME :
                           (g == 3) ? {12'h000, `RST_FB_SRC} :
                           (g == 4) ? `RST_FILT_TIME :
                           (g == 5) ? `RST_FB_GAIN : `RST_DISP_RANGE;
            else if (wr_en && wr_idx == g)
               mem_q[g] <= wr_data;
         end
         assign all_q[g*16 +: 16] = mem_q[g];
      end
   endgenerate

   // Registered read port
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         rd_data <= 16'h0000;
      else if (rd_idx < 3'd7)
         rd_data <= mem_q[rd_idx];
      else
         rd_data <= 16'h0000;
   end
endmodule // param_store

// ===== hw/pid_front_consts.vh
// Constants for the regulator set-point and feedback front end
`ifndef PID_FRONT_CONSTS_VH
`define PID_FRONT_CONSTS_VH
// Register addresses
`define REG_SP_SRC        16'h0d00
`define REG_KEY_VAL       16'h0d01
`define REG_RAMP_TIME     16'h0d02
`define REG_FB_SRC        16'h0d03
`define REG_FILT_TIME     16'h0d04
`define REG_FB_GAIN       16'h0d05
`define REG_DISP_RANGE    16'h0d06
`define REG_COMM_CURRENT  16'h3011
`define REG_SP_APPLIED    16'h0d40
`define REG_FB_FILTERED   16'h0d41
`define REG_FB_DISPLAY    16'h0d42
`define REG_QUICK_EDIT    16'h0d43
// Reset values (0.1 % units, 0.01 s, 0.001 s, 0.01 gain, 0.1 range)
`define RST_SP_SRC        4'h0
`define RST_KEY_VAL       16'h01f4
`define RST_RAMP_TIME     16'h0064
`define RST_FB_SRC        4'h2
`define RST_FILT_TIME     16'h000a
`define RST_FB_GAIN       16'h0064
`define RST_DISP_RANGE    16'h03e8
`define RST_QUICK_EDIT    8'h00
// Limits
`define MAX_PERCENT       16'h03e8
`define MAX_RAMP_TIME     16'h1770
`define MAX_FILT_TIME     16'h1770
`define MAX_FB_GAIN       16'h03e8
`define MAX_DISP_RANGE    16'h03e8
`define MAX_SRC_CODE      4'h9
// Source codes
`define SRC_KEYPAD        4'h0
`define SRC_POT           4'h1
`define SRC_AIN1          4'h2
`define SRC_AIN2          4'h3
`define SRC_RSVD          4'h4
`define SRC_PULSE         4'h5
`define SRC_SERIAL        4'h6
`define SRC_OPTION        4'h7
`define SRC_TERMINAL      4'h8
`define SRC_CURRENT       4'h9
// Quick-edit digits
`define QE_UPDOWN_CODE    4'h2
`define QE_DIGIT0_LSB     0
`define QE_DIGIT1_LSB     4
// Timing: control sample 1 ms
`define SAMPLE_TIME_NS    1000000
`define CLOCK_PERIOD_NS   10
`define SAMPLE_CYCLES     (`SAMPLE_TIME_NS / `CLOCK_PERIOD_NS)
`define SAMPLE_CNT_W      17
// Ramp: full swing of 1000 steps over ramp_time*10 ms samples
`define RAMP_SAMPLES_PER_UNIT 10
`define FILT_SHIFT        10
`endif

// ===== hw/pid_reference_feedback_select.v
// Set-point and feedback selection, ramp, filter, gain and display scaling
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "pid_front_consts.vh"
module pid_reference_feedback_select
(
   input  wire        clock,
   input  wire        reset_n,
   input  wire [15:0] address,
   input  wire [15:0] write_data,
   input  wire        write_strobe,
   input  wire        read_strobe,
   output reg  [15:0] read_data,
   input  wire [15:0] pot_value,
   input  wire [15:0] ain1_value,
   input  wire [15:0] ain2_value,
   input  wire [15:0] pulse_value,
   input  wire [15:0] serial_value,
   input  wire [15:0] option_value,
   input  wire [15:0] local_current,
   input  wire [2:0]  sp_terminals,
   input  wire [2:0]  fb_terminals,
   input  wire        key_up,
   input  wire        key_down,
   output reg  [15:0] setpoint_out,
   output reg  [15:0] setpoint_monitor,
   output reg  [15:0] feedback_out,
   output reg  [15:0] feedback_display,
   output reg         keypad_retain
);
   // Channel selection shared by both selectors
   function [15:0] pick;
      input [3:0]  code;
      input [2:0]  term;
      input [15:0] keyv;
      input [15:0] pot;
      input [15:0] a1;
      input [15:0] a2;
      input [15:0] pul;
      input [15:0] ser;
      input [15:0] opt;
      input [15:0] cur;
      reg   [3:0]  ch;
      begin
         ch = (code == `SRC_TERMINAL) ? {1'b0, term} : code;
         case (ch)
            `SRC_KEYPAD:  pick = keyv;
            `SRC_POT:     pick = pot;
            `SRC_AIN1:    pick = a1;
            `SRC_AIN2:    pick = a2;
            `SRC_PULSE:   pick = pul;
            `SRC_SERIAL:  pick = ser;
            `SRC_OPTION:  pick = opt;
            `SRC_CURRENT: pick = cur;
            default:      pick = 16'h0000;
         endcase
      end
   endfunction

   // Clamp helper for percentage style values
   function [15:0] clamp;
      input [31:0] v;
      input [15:0] lim;
      begin
         clamp = (v > {16'h0000, lim}) ? lim : v[15:0];
      end
   endfunction

   wire [111:0] par;
   wire [15:0]  store_rd;
   reg  [15:0]  key_val_q;
   reg  [15:0]  comm_current_q;
   reg  [7:0]   quick_edit_q;
   reg  [2:0]   sp_t_meta_q;
   reg  [2:0]   sp_t_q;
   reg  [2:0]   fb_t_meta_q;
   reg  [2:0]   fb_t_q;
   reg  [1:0]   key_meta_q;
   reg  [1:0]   key_q;
   reg  [1:0]   key_prev_q;
   reg  [`SAMPLE_CNT_W-1:0] samp_cnt_q;
   reg          tick_q;
   reg  [31:0]  ramp_acc_q;
   reg  [31:0]  filt_acc_q;
   reg  [15:0]  rd_mux_q;
   reg          rd_store_q;
   reg          rd_pend_q;
   wire [3:0]   sp_src = par[3:0];
   wire [15:0]  ramp_time = par[47:32];
   wire [3:0]   fb_src = par[51:48];
   wire [15:0]  filt_time = par[79:64];
   wire [15:0]  fb_gain = par[95:80];
   wire [15:0]  disp_range = par[111:96];
   wire         wr_store = write_strobe && address >= `REG_SP_SRC &&
                           address <= `REG_DISP_RANGE &&
                           address != `REG_KEY_VAL;
   wire [2:0]   wr_idx = address[2:0];
   wire         code_ok = write_data <= {12'h000, `MAX_SRC_CODE};
   wire         up_pulse = key_q[0] && !key_prev_q[0];
   wire         dn_pulse = key_q[1] && !key_prev_q[1];
   wire         quick_on = quick_edit_q[3:0] == `QE_UPDOWN_CODE;
   reg  [15:0]  wr_value;

   // Range-limit written values; bad source codes are dropped
   always @*
   begin
      case (address)
         `REG_RAMP_TIME:  wr_value = clamp({16'h0000, write_data},
                                           `MAX_RAMP_TIME);
         `REG_FILT_TIME:  wr_value = clamp({16'h0000, write_data},
                                           `MAX_FILT_TIME);
         `REG_FB_GAIN:    wr_value = clamp({16'h0000, write_data},
                                           `MAX_FB_GAIN);
         `REG_DISP_RANGE: wr_value = clamp({16'h0000, write_data},
                                           `MAX_DISP_RANGE);
         default:         wr_value = write_data;
      endcase
   end

   param_store u_store
   (
      .clock   (clock),
      .reset_n (reset_n),
      .wr_en   (wr_store && ((address != `REG_SP_SRC &&
                address != `REG_FB_SRC) || code_ok)),
      .wr_idx  (wr_idx),
      .wr_data (wr_value),
      .rd_idx  (address[2:0]),
      .rd_data (store_rd),
      .all_q   (par)
   );

   // Pin inputs pass two flops before use
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sp_t_meta_q <= 3'h0;
         sp_t_q      <= 3'h0;
         fb_t_meta_q <= 3'h0;
         fb_t_q      <= 3'h0;
         key_meta_q  <= 2'h0;
         key_q       <= 2'h0;
         key_prev_q  <= 2'h0;
      end
      else
      begin
         sp_t_meta_q <= sp_terminals;
         sp_t_q      <= sp_t_meta_q;
         fb_t_meta_q <= fb_terminals;
         fb_t_q      <= fb_t_meta_q;
         key_meta_q  <= {key_down, key_up};
         key_q       <= key_meta_q;
         key_prev_q  <= key_q;
      end
   end

   // Keypad value: bus write wins over a key press in the same cycle
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         key_val_q <= `RST_KEY_VAL;
      else if (write_strobe && address == `REG_KEY_VAL)
         key_val_q <= clamp({16'h0000, write_data}, `MAX_PERCENT);
      else if (quick_on && up_pulse && key_val_q < `MAX_PERCENT)
         key_val_q <= key_val_q + 16'h0001;
      else if (quick_on && dn_pulse && key_val_q != 16'h0000)
         key_val_q <= key_val_q - 16'h0001;
   end

   // Host current set value and quick-edit option
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         comm_current_q <= 16'h0000;
         quick_edit_q   <= `RST_QUICK_EDIT;
      end
      else
      begin
         if (write_strobe && address == `REG_COMM_CURRENT)
            comm_current_q <= write_data;
         if (write_strobe && address == `REG_QUICK_EDIT)
            quick_edit_q <= write_data[7:0];
      end
   end

   // Control sample enable
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         samp_cnt_q <= {`SAMPLE_CNT_W{1'b0}};
         tick_q     <= 1'b0;
      end
      else if (samp_cnt_q == `SAMPLE_CYCLES - 1)
      begin
         samp_cnt_q <= {`SAMPLE_CNT_W{1'b0}};
         tick_q     <= 1'b1;
      end
      else
      begin
         samp_cnt_q <= samp_cnt_q + 1'b1;
         tick_q     <= 1'b0;
      end
   end

   // Target set point; monitor follows the target so keypad edits show
   wire [15:0] sp_target = pick(sp_src, sp_t_q, key_val_q, pot_value,
                                ain1_value, ain2_value, pulse_value,
                                serial_value, option_value,
                                comm_current_q);
   wire [15:0] fb_raw = pick(fb_src, fb_t_q, key_val_q, pot_value,
                             ain1_value, ain2_value, pulse_value,
                             serial_value, option_value,
                             local_current);

   // Ramp in 1/2^16 units: step = 1000 / (ramp_time * 10) per sample
   wire [31:0] ramp_target = {sp_target, 16'h0000};
   wire [31:0] ramp_span = ramp_time * `RAMP_SAMPLES_PER_UNIT;
   wire [31:0] ramp_step = (ramp_span == 32'h0) ? 32'hffffffff :
                           ({16'h0000, `MAX_PERCENT} << 16) / ramp_span;
   wire [31:0] ramp_diff = (ramp_acc_q > ramp_target) ?
                           ramp_acc_q - ramp_target :
                           ramp_target - ramp_acc_q;
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         ramp_acc_q <= 32'h0;
      else if (ramp_time == 16'h0000)
         ramp_acc_q <= ramp_target;
      else if (tick_q)
      begin
         if (ramp_diff <= ramp_step)
            ramp_acc_q <= ramp_target;
         else if (ramp_acc_q < ramp_target)
            ramp_acc_q <= ramp_acc_q + ramp_step;
         else
            ramp_acc_q <= ramp_acc_q - ramp_step;
      end
   end

   // Filter: acc += (x - y) * k, k = 1ms/T scaled by 2^FILT_SHIFT
   wire [31:0] filt_in = {fb_raw, 16'h0000};
   wire [31:0] filt_k = (filt_time == 16'h0) ? 32'h0 :
                        (32'h1 << `FILT_SHIFT) / {16'h0000, filt_time};
   wire        filt_up = filt_in >= filt_acc_q;
   wire [31:0] filt_err = filt_up ? filt_in - filt_acc_q :
                          filt_acc_q - filt_in;
   wire [47:0] filt_prod = {16'h0000, filt_err} * filt_k[15:0];
   wire [31:0] filt_step = filt_prod[`FILT_SHIFT +: 32];
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         filt_acc_q <= 32'h0;
      else if (filt_time == 16'h0)
         filt_acc_q <= filt_in;
      else if (tick_q)
         filt_acc_q <= filt_up ? filt_acc_q + filt_step :
                                 filt_acc_q - filt_step;
   end

   // Gain in 0.01 steps, then display scaling in 0.1 steps
   wire [31:0] gained = filt_acc_q[31:16] * fb_gain / 32'd100;
   wire [31:0] disp = gained[15:0] * disp_range / {16'h0000, `MAX_PERCENT};

   // Outputs from flops
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         setpoint_out     <= 16'h0000;
         setpoint_monitor <= 16'h0000;
         feedback_out     <= 16'h0000;
         feedback_display <= 16'h0000;
         keypad_retain    <= 1'b0;
      end
      else
      begin
         setpoint_out     <= ramp_acc_q[31:16];
         setpoint_monitor <= sp_target;
         feedback_out     <= clamp(gained, 16'hffff);
         feedback_display <= clamp(disp, 16'hffff);
         keypad_retain    <= quick_edit_q[`QE_DIGIT1_LSB] ;
      end
   end

   // Read path: status words and keypad value from local flops
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rd_mux_q   <= 16'h0000;
         rd_store_q <= 1'b0;
         rd_pend_q  <= 1'b0;
      end
      else
      begin
         rd_pend_q  <= read_strobe;
         rd_store_q <= address >= `REG_SP_SRC &&
                       address <= `REG_DISP_RANGE &&
                       address != `REG_KEY_VAL;
         case (address)
            `REG_KEY_VAL:      rd_mux_q <= key_val_q;
            `REG_COMM_CURRENT: rd_mux_q <= comm_current_q;
            `REG_SP_APPLIED:   rd_mux_q <= ramp_acc_q[31:16];
            `REG_FB_FILTERED:  rd_mux_q <= filt_acc_q[31:16];
            `REG_FB_DISPLAY:   rd_mux_q <= feedback_display;
            `REG_QUICK_EDIT:   rd_mux_q <= {8'h00, quick_edit_q};
            default:           rd_mux_q <= 16'h0000;
         endcase
      end
   end

   // Read data stand only in the cycle after the strobe
   always @*
   begin
      if (!rd_pend_q)
         read_data = 16'h0000;
      else if (rd_store_q)
         read_data = store_rd;
      else
         read_data = rd_mux_q;
   end
endmodule // pid_reference_feedback_select

// ===== verification/front_sources.sv
// Steady level sources for the analog, pulse, serial and current channels
`timescale 1ns/1ps
module front_sources
(
   output logic [15:0] pot_value,
   output logic [15:0] ain1_value,
   output logic [15:0] ain2_value,
   output logic [15:0] pulse_value,
   output logic [15:0] serial_value,
   output logic [15:0] option_value,
   output logic [15:0] local_current
);
   // Distinct held levels so every channel choice is told apart;
   // steady values keep filter and gain results exact
   assign pot_value     = 16'h0011;
   assign ain1_value    = 16'h0022;
   assign ain2_value    = 16'h0033;
   assign pulse_value   = 16'h0055;
   assign serial_value  = 16'h0066;
   assign option_value  = 16'h0077;
   assign local_current = 16'h0099;
endmodule // front_sources

// ===== verification/pid_front_properties.sv
// Concurrent checks on the set-point and feedback front end
`timescale 1ns/1ps
`include "pid_front_consts.vh"
module pid_front_properties
(
   input wire        clock,
   input wire        reset_n,
   input wire [15:0] address,
   input wire [15:0] write_data,
   input wire        write_strobe,
   input wire        read_strobe,
   input wire [15:0] read_data,
   input wire [15:0] ain1_value,
   input wire [15:0] local_current,
   input wire [15:0] setpoint_out,
   input wire [15:0] setpoint_monitor,
   input wire [15:0] feedback_out,
   input wire [15:0] feedback_display,
   input wire        keypad_retain
);
   logic [3:0]  sp_q, fb_q;
   logic [15:0] key_q, gain_q, range_q;
   logic [7:0]  qe_q;
   logic        ramp0_q, filt0_q;
   logic [31:0] fb_exp, disp_exp;
   wire         key_en = (qe_q[3:0] == `QE_UPDOWN_CODE);
   // Expected scaled values, kept 32 bits wide to avoid overflow
   assign fb_exp = ain1_value * gain_q / 32'd100;
   assign disp_exp = feedback_out * range_q / 32'd1000;
   // Shadow of the parameters; keys make key_q stale, hence key_en guards
   always_ff @(posedge clock or negedge reset_n)
      if (!reset_n)
      begin
         sp_q    <= `RST_SP_SRC;
         fb_q    <= `RST_FB_SRC;
         key_q   <= `RST_KEY_VAL;
         gain_q  <= `RST_FB_GAIN;
         range_q <= `RST_DISP_RANGE;
         qe_q    <= `RST_QUICK_EDIT;
         ramp0_q <= 1'b0;
         filt0_q <= 1'b0;
      end
      else if (write_strobe)
         case (address)
            `REG_SP_SRC: if (write_data < 16'h000a) sp_q <= write_data[3:0];
            `REG_FB_SRC: if (write_data < 16'h000a) fb_q <= write_data[3:0];
            `REG_KEY_VAL: key_q <= (write_data > `MAX_PERCENT) ?
                                   `MAX_PERCENT : write_data;
            `REG_FB_GAIN: gain_q <= (write_data > `MAX_FB_GAIN) ?
                                    `MAX_FB_GAIN : write_data;
            `REG_DISP_RANGE: range_q <= (write_data > `MAX_DISP_RANGE) ?
                                        `MAX_DISP_RANGE : write_data;
            `REG_QUICK_EDIT: qe_q <= write_data[7:0];
            `REG_RAMP_TIME: ramp0_q <= (write_data == 16'h0000);
            `REG_FILT_TIME: filt0_q <= (write_data == 16'h0000);
            default: ;
         endcase
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   AST_SP_SRC_READ:
   assert property (read_strobe && address == `REG_SP_SRC |=>
      read_data == {12'h000, sp_q}) else $error("set-point source read");
   AST_FB_SRC_READ:
   assert property (read_strobe && address == `REG_FB_SRC |=>
      read_data == {12'h000, fb_q}) else $error("feedback source read");
   AST_KEY_READ:
   assert property (read_strobe && address == `REG_KEY_VAL && !key_en |=>
      read_data == key_q) else $error("keypad value read");
   AST_KEY_SETPOINT:
   assert property ((sp_q == `SRC_KEYPAD && !key_en && !write_strobe)[*3]
      |-> setpoint_monitor == key_q) else $error("keypad set point");
   AST_KEY_MONITOR:
   assert property (write_strobe && address == `REG_KEY_VAL && !key_en &&
      sp_q == `SRC_KEYPAD && write_data <= `MAX_PERCENT |-> ##2
      setpoint_monitor == $past(write_data, 2)) else $error("monitor lag");
   AST_RAMP_JUMP:
   assert property ((ramp0_q && $stable(setpoint_monitor))[*4] |->
      setpoint_out == setpoint_monitor) else $error("zero ramp time");
   AST_LOCAL_CURRENT:
   assert property ((fb_q == `SRC_CURRENT && filt0_q && gain_q == 16'h0064
      && $stable(local_current))[*5] |-> feedback_out == local_current)
      else $error("local current feedback");
   AST_FB_GAIN:
   assert property ((fb_q == `SRC_AIN1 && filt0_q && $stable(gain_q) &&
      $stable(ain1_value))[*5] |-> feedback_out == fb_exp[15:0])
      else $error("feedback gain");
   AST_DISPLAY:
   assert property (($stable(feedback_out) && $stable(range_q))[*4] |->
      feedback_display == disp_exp[15:0]) else $error("display scale");
   AST_RETAIN:
   assert property ($stable(qe_q)[*3] |-> keypad_retain == qe_q[4])
      else $error("retain flag");
   cover property (sp_q == `SRC_TERMINAL && fb_q == `SRC_TERMINAL);
   cover property (fb_q == `SRC_CURRENT && filt0_q);
   cover property (key_en && keypad_retain);
endmodule // pid_front_properties

// ===== verification/tb_top.sv
// Self-checking bench for the set-point and feedback front end
`timescale 1ns/1ps
`include "pid_front_consts.vh"
module tb_top;
   logic        clock, reset_n, write_strobe, read_strobe;
   logic        key_up, key_down, keypad_retain;
   logic [15:0] address, write_data, read_data, d, d2;
   logic [15:0] pot_value, ain1_value, ain2_value, pulse_value;
   logic [15:0] serial_value, option_value, local_current;
   logic [15:0] setpoint_out, setpoint_monitor;
   logic [15:0] feedback_out, feedback_display;
   logic [2:0]  sp_terminals, fb_terminals;
   logic [45:0] rows [0:13];
   logic [15:0] rst_v [0:6];
   int          fails, n_checks, cyc;
   pid_reference_feedback_select u_dut (.clock, .reset_n, .address,
      .write_data, .write_strobe, .read_strobe, .read_data, .pot_value,
      .ain1_value, .ain2_value, .pulse_value, .serial_value, .option_value,
      .local_current, .sp_terminals, .fb_terminals, .key_up, .key_down,
      .setpoint_out, .setpoint_monitor, .feedback_out, .feedback_display,
      .keypad_retain);
   front_sources u_src (.pot_value, .ain1_value, .ain2_value,
      .pulse_value, .serial_value, .option_value, .local_current);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] v);
      @(posedge clock);
      address <= a;
      write_data <= v;
      write_strobe <= 1'b1;
      @(posedge clock);
      write_strobe <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] v);
      @(posedge clock);
      address <= a;
      read_strobe <= 1'b1;
      @(posedge clock);
      read_strobe <= 1'b0;
      #1 v = read_data;
   endtask
   task automatic wait_cy(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // Key held three cycles so the input synchroniser sees one press
   task automatic press(input logic up);
      @(posedge clock);
      key_up <= up;
      key_down <= !up;
      repeat (3) @(posedge clock);
      key_up <= 1'b0;
      key_down <= 1'b0;
      wait_cy(6);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         test_done;
      end
   end
   initial
   begin
      reset_n = 1'b0;
      address = 16'h0000;
      write_data = 16'h0000;
      write_strobe = 1'b0;
      read_strobe = 1'b0;
      key_up = 1'b0;
      key_down = 1'b0;
      sp_terminals = 3'h0;
      fb_terminals = 3'h0;
      rst_v = '{{12'h000, `RST_SP_SRC}, `RST_KEY_VAL, `RST_RAMP_TIME,
         {12'h000, `RST_FB_SRC}, `RST_FILT_TIME, `RST_FB_GAIN,
         `RST_DISP_RANGE};
      // Set code, feedback code, terminals, expected set point, feedback
      rows = '{{4'h0, 4'h2, 3'h0, 3'h0, 16'h0100, 16'h0022},
         {4'h1, 4'h3, 3'h0, 3'h0, 16'h0011, 16'h0033},
         {4'h2, 4'h5, 3'h0, 3'h0, 16'h0022, 16'h0055},
         {4'h3, 4'h6, 3'h0, 3'h0, 16'h0033, 16'h0066},
         {4'h5, 4'h7, 3'h0, 3'h0, 16'h0055, 16'h0077},
         {4'h6, 4'h1, 3'h0, 3'h0, 16'h0066, 16'h0011},
         {4'h7, 4'h0, 3'h0, 3'h0, 16'h0077, 16'h0100},
         {4'h9, 4'h9, 3'h0, 3'h0, 16'h0088, 16'h0099},
         {4'h4, 4'h2, 3'h0, 3'h0, 16'h0000, 16'h0022},
         {4'h8, 4'h8, 3'h2, 3'h7, 16'h0022, 16'h0077},
         {4'h8, 4'h8, 3'h0, 3'h5, 16'h0100, 16'h0055},
         {4'h8, 4'h8, 3'h6, 3'h0, 16'h0066, 16'h0100},
         {4'h8, 4'h8, 3'h4, 3'h3, 16'h0000, 16'h0033},
         {4'h8, 4'h8, 3'h1, 3'h2, 16'h0011, 16'h0022}};
      repeat (8) @(posedge clock);
      chk(setpoint_out, 16'h0000);
      reset_n <= 1'b1;
      wait_cy(3);
      chk(setpoint_monitor, `RST_KEY_VAL);
      for (int i = 0; i < 7; i++)
      begin
         rd(16'(16'h0d00 + i), d);
         chk(d, rst_v[i]);
      end
      $display("reset test done");
      wr(`REG_RAMP_TIME, 16'h0000);
      wr(`REG_FILT_TIME, 16'h0000);
      wr(`REG_KEY_VAL, 16'h0100);
      wr(`REG_COMM_CURRENT, 16'h0088);
      foreach (rows[i])
      begin
         @(posedge clock);
         sp_terminals <= rows[i][37:35];
         fb_terminals <= rows[i][34:32];
         // Feedback first so both never share one channel
         wr(`REG_FB_SRC, {12'h000, rows[i][41:38]});
         wr(`REG_SP_SRC, {12'h000, rows[i][45:42]});
         wait_cy(8);
         chk(setpoint_out, rows[i][31:16]);
         chk(feedback_out, rows[i][15:0]);
         chk(feedback_display, rows[i][15:0]);
      end
      $display("source table done");
      wr(`REG_FB_SRC, 16'h0002);
      wr(`REG_SP_SRC, 16'h0000);
      wr(`REG_SP_SRC, 16'h000a);
      rd(`REG_SP_SRC, d);
      chk(d, 16'h0000);
      wr(`REG_FB_SRC, 16'h000f);
      rd(`REG_FB_SRC, d);
      chk(d, 16'h0002);
      wr(`REG_KEY_VAL, 16'h0500);
      wait_cy(2);
      chk(setpoint_monitor, `MAX_PERCENT);
      rd(`REG_KEY_VAL, d);
      chk(d, `MAX_PERCENT);
      wr(`REG_KEY_VAL, 16'h0100);
      wr(`REG_FB_GAIN, 16'h00c8);
      wait_cy(6);
      chk(feedback_out, 16'h0044);
      wr(`REG_FB_GAIN, 16'h0fff);
      rd(`REG_FB_GAIN, d);
      chk(d, `MAX_FB_GAIN);
      wait_cy(6);
      chk(feedback_out, 16'h0154);
      wr(`REG_FB_GAIN, 16'h0064);
      wr(`REG_DISP_RANGE, 16'h01f4);
      wait_cy(6);
      chk(feedback_display, 16'h0011);
      chk(feedback_out, 16'h0022);
      $display("limits and scaling done");
      wr(`REG_QUICK_EDIT, 16'h0012);
      wait_cy(2);
      chk({15'h0000, keypad_retain}, 16'h0001);
      press(1'b1);
      rd(`REG_KEY_VAL, d);
      chk({15'h0000, d > 16'h0100}, 16'h0001);
      press(1'b0);
      rd(`REG_KEY_VAL, d2);
      chk({15'h0000, d2 < d}, 16'h0001);
      wr(`REG_KEY_VAL, 16'h0100);
      wr(`REG_QUICK_EDIT, 16'h0000);
      press(1'b1);
      rd(`REG_KEY_VAL, d);
      chk(d, 16'h0100);
      chk({15'h0000, keypad_retain}, 16'h0000);
      rd(16'h0d20, d);
      chk(d, 16'h0000);
      $display("keys and unmapped read done");
      @(posedge clock);
      reset_n <= 1'b0;
      @(posedge clock);
      reset_n <= 1'b1;
      rd(`REG_FB_GAIN, d);
      chk(d, `RST_FB_GAIN);
      rd(`REG_DISP_RANGE, d);
      chk(d, `RST_DISP_RANGE);
      $display("second reset done");
      test_done;
   end
endmodule // tb_top
bind pid_reference_feedback_select pid_front_properties u_props (.clock,
   .reset_n, .address, .write_data, .write_strobe, .read_strobe,
   .read_data, .ain1_value, .local_current, .setpoint_out,
   .setpoint_monitor, .feedback_out, .feedback_display, .keypad_retain);
